//--- eqfir_top.v
// Function
// - Equalizer optionally filters converter samples before downstream.
// - Mode 0 disables; mode 2 with share/merge/link picks dual, single, tv.
// - Dual mode filters both channels independently, own filter each.
// - Dual mode uses nine programmable coefficients per channel.
// - Center tap is 18 bits with LSB weight 2^-16.
// - Non-center taps are 12 bits, LSB weight 2^-10 to 2^-16.
// - One LSB weight setting applies to all non-center taps.
// - Single mode applies one nine-tap filter to interleaved stream.
// - Time-varying mode alternates two coefficient sets per sample.
// - Each time-varying set holds nine programmable coefficients.
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "eqfir_regs.vh"

// ----------------------------------------
// Sample FIFO
// ----------------------------------------
module eqfir_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             mclk_in,
    input  wire             rst_n_in,
    input  wire             in_valid_in,
    output reg              in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    output reg              out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    localparam [AW:0] CNT_MAX = DEPTH;
    localparam [AW:0] CNT_ONE = 1;
    localparam [AW-1:0] PTR_ONE = 1;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr;
    reg [AW-1:0]    rd_ptr;
    reg [AW:0]      count;
    reg [AW:0]      next_count;
    wire            push;
    wire            pop;

    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr];

    always @*
    begin
        next_count = count;
        if (push && !pop)
            next_count = count + CNT_ONE;
        else if (pop && !push)
            next_count = count - CNT_ONE;
    end

    // Flags are flops so full and empty never glitch at the ports
    always @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            in_ready_out <= 1'b0;
            out_valid_out <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                mem[wr_ptr] <= in_data_in;
                wr_ptr <= wr_ptr + PTR_ONE;
            end
            if (pop)
                rd_ptr <= rd_ptr + PTR_ONE;
            count <= next_count;
            in_ready_out <= (next_count != CNT_MAX);
            out_valid_out <= (next_count != {(AW+1){1'b0}});
        end
    end
endmodule // eqfir_fifo

// ----------------------------------------
// Equalizer top
// ----------------------------------------
module eqfir_top #(
    parameter DW    = 12,
    parameter DEPTH = 4
) (
    input  wire          mclk_in,
    input  wire          rst_n_in,
    input  wire [7:0]    s_axi_awaddr_in,
    input  wire          s_axi_awvalid_in,
    output reg           s_axi_awready_out,
    input  wire [31:0]   s_axi_wdata_in,
    input  wire [3:0]    s_axi_wstrb_in,
    input  wire          s_axi_wvalid_in,
    output reg           s_axi_wready_out,
    output reg  [1:0]    s_axi_bresp_out,
    output reg           s_axi_bvalid_out,
    input  wire          s_axi_bready_in,
    input  wire [7:0]    s_axi_araddr_in,
    input  wire          s_axi_arvalid_in,
    output reg           s_axi_arready_out,
    output reg  [31:0]   s_axi_rdata_out,
    output reg  [1:0]    s_axi_rresp_out,
    output reg           s_axi_rvalid_out,
    input  wire          s_axi_rready_in,
    input  wire          in_valid_in,
    input  wire [DW-1:0] in_a_in,
    input  wire [DW-1:0] in_b_in,
    output wire          in_ready_out,
    output reg           out_valid_out,
    output reg  [DW-1:0] out_a_out,
    output reg  [DW-1:0] out_b_out,
    input  wire          out_ready_in
);
    localparam ACCW = DW + `EQF_CW + 6;
    localparam QW = ACCW - `EQF_FRAC + 1;
    localparam LW = `EQF_NTAPS * DW;
    localparam [QW-1:0] Q_ONE = 1;
    localparam signed [QW-1:0] QMAX = {{(QW-DW+1){1'b0}}, {(DW-1){1'b1}}};
    localparam signed [QW-1:0] QMIN = {{(QW-DW+1){1'b1}}, {(DW-1){1'b0}}};

    reg [`EQF_CW-1:0] coef_a [0:`EQF_NTAPS-1];
    reg [`EQF_CW-1:0] coef_b [0:`EQF_NTAPS-1];
    reg [1:0]         filter_mode_select;
    reg               coeff_share_flag;
    reg               channel_merge_flag;
    reg [2:0]         wgt;
    reg [1:0]         link_mode_select;
    reg [1:0]         act;
    reg [LW-1:0]      line_a;
    reg [LW-1:0]      line_b;
    reg [LW+DW-1:0]   line_il;
    reg [DW-1:0]      next_ya;
    reg [DW-1:0]      next_yb;
    reg [7:0]         aw_addr;
    reg [31:0]        w_data;
    reg [3:0]         w_strb;
    reg               aw_got;
    reg               w_got;
    reg [31:0]        wr_val;
    wire              f_valid;
    wire              f_ready;
    wire [2*DW-1:0]   f_data;
    wire              take;
    wire [LW-1:0]     next_line_a;
    wire [LW-1:0]     next_line_b;
    wire [LW+DW-1:0]  next_line_il;
    integer           i;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Address kind: 0 none, 1 ctrl, 2 status, 3 coef A, 4 coef B
    function [2:0] addr_kind;
        input [7:0] a;
        begin
            addr_kind = 3'h0;
            if (a == `EQF_CTRL_ADDR)
                addr_kind = 3'h1;
            else if (a == `EQF_STAT_ADDR)
                addr_kind = 3'h2;
            else if (a[5:2] < `EQF_NTAPS && a[1:0] == 2'h0)
            begin
                if (a[7:6] == `EQF_CA_BASE)
                    addr_kind = 3'h3;
                else if (a[7:6] == `EQF_CB_BASE)
                    addr_kind = 3'h4;
            end
        end
    endfunction

    function [31:0] lanes;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  st;
        integer b;
        begin
            lanes = old;
            for (b = 0; b < 4; b = b + 1)
                if (st[b])
                    lanes[b*8+:8] = nw[b*8+:8];
        end
    endfunction

    // exact sum
    // Full-width sum keeps every product bit; only the result is rounded
    function [DW-1:0] fir;
        input [LW-1:0] s;
        input          sel;
        reg signed [ACCW-1:0] acc;
        reg signed [ACCW-1:0] p;
        reg signed [QW-1:0]   q;
        reg [`EQF_CW-1:0]     c;
        integer k;
        begin
            acc = {ACCW{1'b0}};
            for (k = 0; k < `EQF_NTAPS; k = k + 1)
            begin
                c = sel ? coef_b[k] : coef_a[k];
                if (k == `EQF_CTR)
                    p = $signed(s[k*DW+:DW]) * $signed(c);
                else
                    p = ($signed(s[k*DW+:DW])
                        * $signed(c[`EQF_NCW-1:0]))
                        <<< (`EQF_WGT_MAX - wgt);
                acc = acc + p;
            end
            q = {acc[ACCW-1], acc[ACCW-1:`EQF_FRAC]};
            if (acc[`EQF_FRAC-1]
                && (acc[`EQF_FRAC-2:0] != 0 || q[0]))
                q = q + Q_ONE;
            if (q > QMAX)
                fir = QMAX[DW-1:0];
            else if (q < QMIN)
                fir = QMIN[DW-1:0];
            else
                fir = q[DW-1:0];
        end
    endfunction

    // ----------------------------------------
    // Input buffer
    // ----------------------------------------
    eqfir_fifo #(
        .WIDTH (2*DW),
        .DEPTH (DEPTH),
        .AW    (2)
    ) eqfir_fifo_inst (
        .mclk_in       (mclk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (in_valid_in),
        .in_ready_out  (in_ready_out),
        .in_data_in    ({in_b_in, in_a_in}),
        .out_valid_out (f_valid),
        .out_ready_in  (f_ready),
        .out_data_out  (f_data)
    );

    // Downstream stall holds the filter and lets the FIFO fill
    assign f_ready = !out_valid_out || out_ready_in;
    assign take = f_valid && f_ready;
    assign next_line_a = {line_a[LW-DW-1:0], f_data[DW-1:0]};
    assign next_line_b = {line_b[LW-DW-1:0], f_data[2*DW-1:DW]};
    // Interleaved order: A sample precedes B sample
    assign next_line_il = {line_il[LW-DW-1:0], f_data[DW-1:0],
                           f_data[2*DW-1:DW]};

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    always @*
    begin
        act = `EQF_ACT_BYP;
        if (filter_mode_select == `EQF_MODE_ON)
        begin
            if (!coeff_share_flag && !channel_merge_flag
                && link_mode_select == `EQF_LINK_DUAL)
                act = `EQF_ACT_DUAL;
            else if (coeff_share_flag && channel_merge_flag
                && link_mode_select == `EQF_LINK_SING)
                act = `EQF_ACT_SING;
            else if (!coeff_share_flag && channel_merge_flag
                && link_mode_select == `EQF_LINK_DISC)
                act = `EQF_ACT_TV;
        end
    end

    // ----------------------------------------
    // Filter datapath
    // ----------------------------------------
    always @*
    begin
        case (act)
            `EQF_ACT_DUAL:
            begin
                next_ya = fir(next_line_a, 1'b0);
                next_yb = fir(next_line_b, 1'b1);
            end
            `EQF_ACT_SING:
            begin
                next_ya = fir(next_line_il[LW+DW-1:DW], 1'b0);
                next_yb = fir(next_line_il[LW-1:0], 1'b0);
            end
            `EQF_ACT_TV:
            begin
                next_ya = fir(next_line_il[LW+DW-1:DW], 1'b0);
                next_yb = fir(next_line_il[LW-1:0], 1'b1);
            end
            default:
            begin
                next_ya = f_data[DW-1:0];
                next_yb = f_data[2*DW-1:DW];
            end
        endcase
    end

    // optional filtering
    // Delay lines shift in every mode so a mode switch has history
    always @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            line_a <= {LW{1'b0}};
            line_b <= {LW{1'b0}};
            line_il <= {(LW+DW){1'b0}};
            out_valid_out <= 1'b0;
            out_a_out <= {DW{1'b0}};
            out_b_out <= {DW{1'b0}};
        end
        else if (take)
        begin
            line_a <= next_line_a;
            line_b <= next_line_b;
            line_il <= next_line_il;
            out_valid_out <= 1'b1;
            out_a_out <= next_ya;
            out_b_out <= next_yb;
        end
        else if (out_ready_in)
            out_valid_out <= 1'b0;
    end

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    always @*
    begin
        case (addr_kind(aw_addr))
            3'h1: wr_val = lanes({22'h0, link_mode_select, 1'b0,
                                  wgt, channel_merge_flag,
                                  coeff_share_flag,
                                  filter_mode_select},
                                 w_data, w_strb);
            3'h3: wr_val = lanes({14'h0, coef_a[aw_addr[5:2]]},
                                 w_data, w_strb);
            3'h4: wr_val = lanes({14'h0, coef_b[aw_addr[5:2]]},
                                 w_data, w_strb);
            default: wr_val = 32'h0;
        endcase
    end

    // Coefficients act at once: software loads them before enabling
    // load first
    always @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= `EQF_RESP_OK;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            filter_mode_select <= 2'h0;
            coeff_share_flag <= 1'b0;
            channel_merge_flag <= 1'b0;
            wgt <= 3'h0;
            link_mode_select <= `EQF_LINK_DUAL;
            for (i = 0; i < `EQF_NTAPS; i = i + 1)
            begin
                coef_a[i] <= {`EQF_CW{1'b0}};
                coef_b[i] <= {`EQF_CW{1'b0}};
            end
        end
        else
        begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
                aw_addr <= s_axi_awaddr_in;
                aw_got <= 1'b1;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
                w_data <= s_axi_wdata_in;
                w_strb <= s_axi_wstrb_in;
                w_got <= 1'b1;
                s_axi_wready_out <= 1'b0;
            end
            if (aw_got && w_got && !s_axi_bvalid_out)
            begin
                aw_got <= 1'b0;
                w_got <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= (addr_kind(aw_addr) == 3'h0)
                    ? `EQF_RESP_ERR : `EQF_RESP_OK;
                case (addr_kind(aw_addr))
                    3'h1:
                    begin
                        filter_mode_select <= wr_val[`EQF_MODE_LSB+:2];
                        coeff_share_flag <= wr_val[`EQF_SHARE_BIT];
                        channel_merge_flag <= wr_val[`EQF_MERGE_BIT];
                        wgt <= (wr_val[`EQF_WGT_LSB+:3] > `EQF_WGT_MAX)
                            ? `EQF_WGT_MAX : wr_val[`EQF_WGT_LSB+:3];
                        link_mode_select <= wr_val[`EQF_LINK_LSB+:2];
                    end
                    3'h3: coef_a[aw_addr[5:2]] <=
                        (aw_addr[5:2] == `EQF_CTR) ? wr_val[`EQF_CW-1:0]
                        : {6'h0, wr_val[`EQF_NCW-1:0]};
                    3'h4: coef_b[aw_addr[5:2]] <=
                        (aw_addr[5:2] == `EQF_CTR) ? wr_val[`EQF_CW-1:0]
                        : {6'h0, wr_val[`EQF_NCW-1:0]};
                    default:
                    begin
                    end
                endcase
            end
            if (s_axi_bvalid_out && s_axi_bready_in)
            begin
                s_axi_bvalid_out <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out <= 1'b1;
            end
        end
    end

    always @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0;
            s_axi_rresp_out <= `EQF_RESP_OK;
        end
        else if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= `EQF_RESP_OK;
            case (addr_kind(s_axi_araddr_in))
                3'h1: s_axi_rdata_out <= {22'h0, link_mode_select, 1'b0,
                    wgt, channel_merge_flag, coeff_share_flag,
                    filter_mode_select};
                3'h2: s_axi_rdata_out <= {28'h0, !in_ready_out,
                    out_valid_out, act};
                3'h3: s_axi_rdata_out <=
                    {14'h0, coef_a[s_axi_araddr_in[5:2]]};
                3'h4: s_axi_rdata_out <=
                    {14'h0, coef_b[s_axi_araddr_in[5:2]]};
                default:
                begin
                    s_axi_rdata_out <= 32'h0;
                    s_axi_rresp_out <= `EQF_RESP_ERR;
                end
            endcase
        end
        else if (s_axi_rvalid_out && s_axi_rready_in)
        begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end
endmodule // eqfir_top
`default_nettype wire

//--- eqfir_regs.vh
`ifndef EQFIR_REGS_VH
`define EQFIR_REGS_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define EQF_CTRL_ADDR   8'h00
`define EQF_STAT_ADDR   8'h04
`define EQF_CA_BASE     2'h1
`define EQF_CB_BASE     2'h2

// ----------------------------------------
// Control fields
// ----------------------------------------
`define EQF_MODE_LSB    0
`define EQF_SHARE_BIT   2
`define EQF_MERGE_BIT   3
`define EQF_WGT_LSB     4
`define EQF_LINK_LSB    8
`define EQF_CTRL_RST    32'h0000_0000
`define EQF_MODE_ON     2'h2
`define EQF_LINK_DUAL   2'h0
`define EQF_LINK_SING   2'h1
`define EQF_LINK_DISC   2'h2
`define EQF_WGT_MAX     3'h6

// ----------------------------------------
// Status fields
// ----------------------------------------
`define EQF_ACT_BYP     2'h0
`define EQF_ACT_DUAL    2'h1
`define EQF_ACT_SING    2'h2
`define EQF_ACT_TV      2'h3
`define EQF_OVLD_BIT    2
`define EQF_FULL_BIT    3

// ----------------------------------------
// Filter shape
// ----------------------------------------
`define EQF_NTAPS       9
`define EQF_CTR         4
`define EQF_CW          18
`define EQF_NCW         12
`define EQF_FRAC        16

// ----------------------------------------
// Bus answers
// ----------------------------------------
`define EQF_RESP_OK     2'h0
`define EQF_RESP_ERR    2'h2

`endif

//--- eqfir_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Port checker
// ------------------------------
module eqfir_monitor #(
    parameter DW    = 12,
    parameter DEPTH = 4
) (
    input wire logic          mclk_in,
    input wire logic          rst_n_in,
    input wire logic          s_axi_awvalid_in,
    input wire logic          s_axi_awready_out,
    input wire logic          s_axi_wvalid_in,
    input wire logic          s_axi_wready_out,
    input wire logic [1:0]    s_axi_bresp_out,
    input wire logic          s_axi_bvalid_out,
    input wire logic          s_axi_bready_in,
    input wire logic          s_axi_arvalid_in,
    input wire logic          s_axi_arready_out,
    input wire logic [31:0]   s_axi_rdata_out,
    input wire logic          s_axi_rvalid_out,
    input wire logic          s_axi_rready_in,
    input wire logic          in_valid_in,
    input wire logic          in_ready_out,
    input wire logic          out_valid_out,
    input wire logic [DW-1:0] out_a_out,
    input wire logic [DW-1:0] out_b_out,
    input wire logic          out_ready_in
);
    default clocking mcb @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence wr_taken;
        s_axi_awvalid_in && s_axi_awready_out &&
        s_axi_wvalid_in && s_axi_wready_out;
    endsequence
    sequence push_idle;
        in_valid_in && in_ready_out && !out_valid_out;
    endsequence

    a_write_answer:
        assert property (wr_taken |=> ##1 s_axi_bvalid_out)
        else $error("write answer late");
    a_read_answer:
        assert property (s_axi_arvalid_in && s_axi_arready_out
            |=> s_axi_rvalid_out)
        else $error("read answer late");
    a_bresp_hold:
        assert property (s_axi_bvalid_out && !s_axi_bready_in
            |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
        else $error("write response dropped");
    a_rdata_hold:
        assert property (s_axi_rvalid_out && !s_axi_rready_in
            |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
        else $error("read data dropped");
    a_bus_blocked:
        assert property ((!s_axi_bvalid_out ||
            (!s_axi_awready_out && !s_axi_wready_out)) &&
            (!s_axi_rvalid_out || !s_axi_arready_out))
        else $error("new request accepted while busy");
    a_out_latency:
        assert property (push_idle |=> ##1 out_valid_out)
        else $error("sample not delivered in two cycles");
    a_out_hold:
        assert property (out_valid_out && !out_ready_in |=> out_valid_out
            && $stable(out_a_out) && $stable(out_b_out))
        else $error("output pair changed under stall");
    a_reset_idle:
        assert property ($rose(rst_n_in) |-> !s_axi_bvalid_out &&
            !s_axi_rvalid_out && !out_valid_out && !in_ready_out)
        else $error("outputs busy after reset");
endmodule // eqfir_monitor

bind eqfir_top eqfir_monitor #(.DW(DW), .DEPTH(DEPTH)) eqfir_monitor_inst (.*);
`default_nettype wire

//--- eqfir_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------
// Downstream sink
// ------------------------------
module eqfir_sink (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic stall_in,
    input wire logic slow_in,
    output logic     ready_out
);
    // downstream back-pressure
    // Slow mode halves throughput so the FIFO fills during filter runs
    always @(posedge mclk_in)
    begin
        if (!rst_n_in || stall_in)
            ready_out <= 1'b0;
        else
            ready_out <= slow_in ? ~ready_out : 1'b1;
    end
endmodule // eqfir_sink
`default_nettype wire

//--- eqfir_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module eqfir_top_tb;
    logic        mclk_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [7:0]  s_axi_awaddr_in = 8'h00;
    logic [7:0]  s_axi_araddr_in = 8'h00;
    logic [31:0] s_axi_wdata_in = 32'h0;
    logic [3:0]  s_axi_wstrb_in = 4'hf;
    logic        s_axi_awvalid_in = 1'b0;
    logic        s_axi_wvalid_in = 1'b0;
    logic        s_axi_bready_in = 1'b0;
    logic        s_axi_arvalid_in = 1'b0;
    logic        s_axi_rready_in = 1'b0;
    logic        in_valid_in = 1'b0;
    logic [11:0] in_a_in = 12'h000;
    logic [11:0] in_b_in = 12'h000;
    logic        stall = 1'b0;
    logic        slow = 1'b0;
    wire         s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    wire         s_axi_arready_out, s_axi_rvalid_out, in_ready_out;
    wire         out_valid_out, out_ready_in;
    wire [1:0]   s_axi_bresp_out, s_axi_rresp_out;
    wire [31:0]  s_axi_rdata_out;
    wire [11:0]  out_a_out, out_b_out;
    logic [11:0] qa [$];
    logic [11:0] qb [$];
    int          n_errors = 0;
    int          cmp_count = 0;

    eqfir_top #(.DW(12), .DEPTH(4)) eqfir_top_inst (.*);
    eqfir_sink eqfir_sink_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .stall_in(stall), .slow_in(slow), .ready_out(out_ready_in));

    initial
    begin
        forever #12.5 mclk_in = ~mclk_in;
    end

    always @(posedge mclk_in)
    begin
        if (rst_n_in && out_valid_out && out_ready_in)
        begin
            qa.push_back(out_a_out);
            qb.push_back(out_b_out);
        end
    end
// ------------------------------
// Shared tasks
// ------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Ready stands with the request; answers are taken at their edge
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= d;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        do
        begin
            @(posedge mclk_in);
            if (s_axi_awready_out)
                s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out)
                s_axi_wvalid_in <= 1'b0;
        end
        while (s_axi_bvalid_out !== 1'b1);
        chk(s_axi_bresp_out, er);
        s_axi_bready_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do
        begin
            @(posedge mclk_in);
            if (s_axi_arready_out)
                s_axi_arvalid_in <= 1'b0;
        end
        while (s_axi_rvalid_out !== 1'b1);
        chk(s_axi_rdata_out, ed);
        chk(s_axi_rresp_out, er);
        s_axi_rready_in <= 1'b0;
        @(posedge mclk_in);
    endtask

    // Impulse of 1024 on A (and B where used) against the loaded sets
    function automatic int ev(input int m, input int c, input int n);
        int k;
        k = (m == 2 || m == 3) ? 2 * n + c : n;
        if (k > 8) return 0;
        if (m == 0) return (k == 0) ? 1024 : 0;
        if (c == 1 && m != 2) return (k == 4) ? 512 : (m == 4) ? k + 1 : 2 * k + 2;
        if (m == 4) return (k == 4) ? 2047 : ((k + 1) >> 1) + ((k + 1) & (k + 1) >> 1 & 1);
        return (k == 4) ? 1024 : k + 1;
    endfunction

    task t_run(input logic [31:0] ctrl, input int m);
        int i;
        qa.delete();
        qb.delete();
        wr(8'h00, ctrl, 2'h0);
        for (i = 0; i < 10; i++)
        begin
            in_valid_in <= 1'b1;
            in_a_in <= (i == 0) ? 12'h400 : 12'h000;
            in_b_in <= (i == 0 && m != 2 && m != 3) ? 12'h400 : 12'h000;
            @(negedge mclk_in);
            while (in_ready_out !== 1'b1) @(negedge mclk_in);
            @(posedge mclk_in);
        end
        in_valid_in <= 1'b0;
        i = 0;
        while (qa.size() < 10 && i < 200)
        begin
            @(posedge mclk_in);
            i++;
        end
        chk(qa.size(), 10);
        for (i = 0; i < 10 && i < qa.size(); i++)
        begin
            chk(qa[i], ev(m, 0, i));
            chk(qb[i], ev(m, 1, i));
        end
    endtask
// ------------------------------
// Scenarios
// ------------------------------
    task t_regs;
        rd(8'h00, 32'h0, 2'h0);
        wr(8'h40, 32'hffffffff, 2'h0);
        rd(8'h40, 32'hfff, 2'h0);
        s_axi_wstrb_in <= 4'h2;
        wr(8'h40, 32'h0, 2'h0);
        s_axi_wstrb_in <= 4'hf;
        rd(8'h40, 32'hff, 2'h0);
        wr(8'h50, 32'hffffffff, 2'h0);
        rd(8'h50, 32'h3ffff, 2'h0);
        wr(8'h00, 32'h70, 2'h0);
        rd(8'h00, 32'h60, 2'h0);
        wr(8'h3c, 32'h1, 2'h2);
        rd(8'h3c, 32'h0, 2'h2);
        wr(8'h04, 32'hff, 2'h0);
        rd(8'h04, 32'h0, 2'h0);
    endtask

    task t_modes;
        logic [11:0] mt [9];
        int i;
        mt = '{12'h000, 12'h402, 12'h90e, 12'he0a, 12'h00e, 12'h106,
               12'h001, 12'h003, 12'h10c};
        for (i = 0; i < 9; i++)
        begin
            wr(8'h00, {22'h0, mt[i][9:0]}, 2'h0);
            rd(8'h04, {30'h0, mt[i][11:10]}, 2'h0);
        end
    endtask

    task t_filters;
        logic [3:0] k;
        slow <= 1'b1;
        for (k = 0; k < 9; k++)
        begin
            wr({2'h1, k, 2'h0}, k == 4 ? 32'h10000 : k + 1, 2'h0);
            wr({2'h2, k, 2'h0}, k == 4 ? 32'h8000 : 2 * k + 2, 2'h0);
        end
        t_run(32'h000, 0);
        t_run(32'h002, 1);
        t_run(32'h10e, 2);
        t_run(32'h20a, 3);
        wr(8'h50, 32'h1ffff, 2'h0);
        t_run(32'h012, 4);
    endtask

    task t_fifo;
        int acc;
        int i;
        logic r;
        wr(8'h00, 32'h0, 2'h0);
        qa.delete();
        stall <= 1'b1;
        acc = 0;
        repeat (2) @(posedge mclk_in);
        in_a_in <= 12'h000;
        in_valid_in <= 1'b1;
        repeat (8)
        begin
            @(negedge mclk_in);
            r = in_ready_out;
            @(posedge mclk_in);
            if (r === 1'b1)
            begin
                acc++;
                in_a_in <= acc[11:0];
            end
        end
        chk(acc, 5);
        rd(8'h04, 32'hc, 2'h0);
        stall <= 1'b0;
        @(negedge mclk_in);
        while (in_ready_out !== 1'b1) @(negedge mclk_in);
        @(posedge mclk_in);
        in_valid_in <= 1'b0;
        i = 0;
        while (qa.size() < 6 && i < 100)
        begin
            @(posedge mclk_in);
            i++;
        end
        chk(qa.size(), 6);
        for (i = 0; i < 6 && i < qa.size(); i++) chk(qa[i], i);
        rd(8'h04, 32'h0, 2'h0);
    endtask

    task stop_test;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #100000;
        n_errors++;
        stop_test;
    end

    initial
    begin
        repeat (3) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(posedge mclk_in);
        t_regs;
        t_modes;
        t_filters;
        t_fifo;
        stop_test;
    end
endmodule // eqfir_top_tb
`default_nettype wire
